// ---- motion_decoder.sv ----
// Decoder turning a quadrature or tach pair into clock, direction and frame position.
// Assumes a Wishbone classic master on the same clock; motion pins are asynchronous.
`timescale 1ns/100ps

// Overview of operation
// - Motion pulses become a clock reference
// - Quadrature direction from which input rises first
// - Swapped lead reports the opposite direction
// - Setting chooses first-leads or second-leads forward
// - Tach mode: first input is the pulse train
// - Tach mode: second input is a direction level
// - Setting chooses low or high as forward
// - Position counts from a preloaded start frame
// - Rate code for 30, 29.97, 25, 24, drop-frame variants is stored and read back only
// - Pulses per frame programmable, default one hundred
module motion_decoder #(
    parameter int PPF_WIDTH = 16,
    parameter int POS_WIDTH = 24
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic motion_a,
    input wire logic motion_b,
    output logic clock_ref_r,
    output logic direction_r,
    output logic [POS_WIDTH-1:0] position_r
);

    // ****************************************************************
    // Input synchronisers
    // ****************************************************************
    logic [1:0] a_sync_r;
    logic [1:0] b_sync_r;
    logic a_prev_r;
    logic b_prev_r;

    // Two stages per pin; only stage 1 is read by logic
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            a_sync_r <= 2'h0;
            b_sync_r <= 2'h0;
        end else begin
            a_sync_r <= {a_sync_r[0], motion_a};
            b_sync_r <= {b_sync_r[0], motion_b};
        end
    end

    // Previous samples for edge detection
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            a_prev_r <= 1'b0;
            b_prev_r <= 1'b0;
        end else begin
            a_prev_r <= a_sync_r[1];
            b_prev_r <= b_sync_r[1];
        end
    end

    // ****************************************************************
    // Configuration registers
    // ****************************************************************
    logic quadrature_mode_r;
    logic polarity_r;
    logic [2:0] rate_r;
    logic [PPF_WIDTH-1:0] ppf_r;
    logic [POS_WIDTH-1:0] start_r;
    logic load_pulse_r;
    logic loaded_r;
    logic bus_hit;
    logic wr_en;

    assign bus_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr_en = bus_hit && wb_we_i;

    // Software writes; byte lane 0 carries mode, polarity and rate, lane 1 the load bit
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            quadrature_mode_r <= ~motion_decoder_pkg::MODE_DEFAULT;
            polarity_r <= motion_decoder_pkg::POL_DEFAULT;
            rate_r <= motion_decoder_pkg::RATE_30;
            ppf_r <= PPF_WIDTH'(motion_decoder_pkg::PPF_DEFAULT);
            start_r <= '0;
            load_pulse_r <= 1'b0;
        end else begin
            load_pulse_r <= 1'b0;
            if (wr_en) begin
                if (wb_adr_i == motion_decoder_pkg::ADDR_CTRL) begin
                    if (wb_sel_i[0]) begin
                        quadrature_mode_r <= wb_dat_i[motion_decoder_pkg::CTRL_MODE_BIT];
                        polarity_r <= wb_dat_i[motion_decoder_pkg::CTRL_POL_BIT];
                        rate_r <= wb_dat_i[motion_decoder_pkg::CTRL_RATE_MSB:
                                           motion_decoder_pkg::CTRL_RATE_LSB];
                    end
                    if (wb_sel_i[1]) begin
                        load_pulse_r <= wb_dat_i[motion_decoder_pkg::CTRL_LOAD_BIT];
                    end
                end else if (wb_adr_i == motion_decoder_pkg::ADDR_PPF) begin
                    ppf_r <= wb_dat_i[PPF_WIDTH-1:0];
                end else if (wb_adr_i == motion_decoder_pkg::ADDR_START) begin
                    start_r <= wb_dat_i[POS_WIDTH-1:0];
                end
            end
        end
    end

    // ****************************************************************
    // Direction and pulse decode
    // ****************************************************************
    logic a_rise;
    logic b_rise;
    logic step;
    logic fwd_now;

    // Quadrature: on a rise of A, B low means A leads; tach: B level is direction
    always_comb begin
        a_rise = a_sync_r[1] && !a_prev_r;
        b_rise = b_sync_r[1] && !b_prev_r;
        step = a_rise;
        if (quadrature_mode_r) begin
            fwd_now = (!b_sync_r[1]) ^ polarity_r;
        end else begin
            fwd_now = b_sync_r[1] ^ ~polarity_r;
        end
    end

    // Direction is latched only when a pulse is counted
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            direction_r <= 1'b1;
        end else if (step) begin
            direction_r <= fwd_now;
        end
    end

    // Clock reference follows the counted pulse train
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            clock_ref_r <= 1'b0;
        end else begin
            clock_ref_r <= step;
        end
    end

    // ****************************************************************
    // Position counter
    // ****************************************************************
    logic [PPF_WIDTH-1:0] phase_r;
    logic frame_tick_r;

    // Partial count tracks direction; frame steps on wrap either way
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            phase_r <= '0;
            position_r <= '0;
            loaded_r <= 1'b0;
            frame_tick_r <= 1'b0;
        end else begin
            frame_tick_r <= 1'b0;
            if (load_pulse_r) begin
                position_r <= start_r;
                phase_r <= '0;
                loaded_r <= 1'b1;
            end else if (step && loaded_r) begin
                if (fwd_now) begin
                    if (phase_r >= ppf_r - PPF_WIDTH'(1)) begin
                        phase_r <= '0;
                        position_r <= position_r + POS_WIDTH'(1);
                        frame_tick_r <= 1'b1;
                    end else begin
                        phase_r <= phase_r + PPF_WIDTH'(1);
                    end
                end else begin
                    if (phase_r == '0) begin
                        phase_r <= ppf_r - PPF_WIDTH'(1);
                        position_r <= position_r - POS_WIDTH'(1);
                        frame_tick_r <= 1'b1;
                    end else begin
                        phase_r <= phase_r - PPF_WIDTH'(1);
                    end
                end
            end
        end
    end

    // ****************************************************************
    // Wishbone read and acknowledge
    // ****************************************************************
    // One-cycle ack; unmapped addresses read zero and writes vanish
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= motion_decoder_pkg::WORD_ZERO;
        end else begin
            wb_ack_o <= bus_hit;
            wb_dat_o <= motion_decoder_pkg::WORD_ZERO;
            if (bus_hit && !wb_we_i) begin
                if (wb_adr_i == motion_decoder_pkg::ADDR_CTRL) begin
                    wb_dat_o[motion_decoder_pkg::CTRL_MODE_BIT] <= quadrature_mode_r;
                    wb_dat_o[motion_decoder_pkg::CTRL_POL_BIT] <= polarity_r;
                    wb_dat_o[motion_decoder_pkg::CTRL_RATE_MSB:
                             motion_decoder_pkg::CTRL_RATE_LSB] <= rate_r;
                    wb_dat_o[motion_decoder_pkg::STAT_DIR_BIT] <= direction_r;
                    wb_dat_o[motion_decoder_pkg::STAT_LOADED_BIT] <= loaded_r;
                    wb_dat_o[motion_decoder_pkg::STAT_TICK_BIT] <= frame_tick_r;
                end else if (wb_adr_i == motion_decoder_pkg::ADDR_PPF) begin
                    wb_dat_o[PPF_WIDTH-1:0] <= ppf_r;
                end else if (wb_adr_i == motion_decoder_pkg::ADDR_START) begin
                    wb_dat_o[POS_WIDTH-1:0] <= start_r;
                end else if (wb_adr_i == motion_decoder_pkg::ADDR_POS) begin
                    wb_dat_o[POS_WIDTH-1:0] <= position_r;
                end
            end
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    property p_sync_delay;
        @(posedge clock) disable iff (reset)
        1'b1 |=> (a_sync_r[1] == $past(a_sync_r[0]));
    endproperty
    a_sync_delay: assert property (p_sync_delay) else $error("sync stage slip");

    property p_clock_ref;
        @(posedge clock) disable iff (reset)
        (a_sync_r[1] && !a_prev_r) |=> clock_ref_r;
    endproperty
    a_clock_ref: assert property (p_clock_ref) else $error("pulse lost");

    property p_quad_dir;
        @(posedge clock) disable iff (reset)
        (step && quadrature_mode_r) |=> (direction_r == ($past(!b_sync_r[1]) ^ polarity_r));
    endproperty
    a_quad_dir: assert property (p_quad_dir) else $error("quadrature direction wrong");

    property p_tach_dir;
        @(posedge clock) disable iff (reset)
        (step && !quadrature_mode_r) |=> (direction_r == ($past(b_sync_r[1]) ^ !polarity_r));
    endproperty
    a_tach_dir: assert property (p_tach_dir) else $error("tach direction wrong");

    property p_load;
        @(posedge clock) disable iff (reset)
        load_pulse_r |=> (position_r == $past(start_r)) && loaded_r;
    endproperty
    a_load: assert property (p_load) else $error("start frame not loaded");

    property p_no_count_unloaded;
        @(posedge clock) disable iff (reset)
        (!loaded_r && !load_pulse_r) |=> $stable(position_r);
    endproperty
    a_no_count_unloaded: assert property (p_no_count_unloaded) else $error("count before load");

    property p_frame_fwd;
        @(posedge clock) disable iff (reset)
        (frame_tick_r && $past(fwd_now)) |-> (position_r == $past(position_r) + POS_WIDTH'(1));
    endproperty
    a_frame_fwd: assert property (p_frame_fwd) else $error("forward frame step wrong");

    property p_phase_bound;
        @(posedge clock) disable iff (reset)
        (loaded_r && ppf_r != '0 && $stable(ppf_r)) |-> ##1 (phase_r < ppf_r || $changed(ppf_r));
    endproperty
    a_phase_bound: assert property (p_phase_bound) else $error("partial count overran");

    property p_ack_one;
        @(posedge clock) disable iff (reset)
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_one: assert property (p_ack_one) else $error("ack held too long");

endmodule // motion_decoder

// ---- motion_decoder_pkg.sv ----
// Package: constants for the two-wire motion decoder.
// Assumes a single 50 MHz system clock and a Wishbone classic register bus.
package motion_decoder_pkg;

    // ****************************************************************
    // Register map (byte addresses, one aligned word each)
    // ****************************************************************
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_PPF = 4'h4;
    localparam logic [3:0] ADDR_START = 4'h8;
    localparam logic [3:0] ADDR_POS = 4'hC;

    // ****************************************************************
    // Control register fields
    // ****************************************************************
    localparam int CTRL_MODE_BIT = 0;
    localparam int CTRL_POL_BIT = 1;
    localparam int CTRL_RATE_LSB = 4;
    localparam int CTRL_RATE_MSB = 6;
    localparam int CTRL_LOAD_BIT = 8;

    // ****************************************************************
    // Status bits inside the control word read-back
    // ****************************************************************
    localparam int STAT_DIR_BIT = 16;
    localparam int STAT_LOADED_BIT = 17;
    localparam int STAT_TICK_BIT = 18;

    // ****************************************************************
    // Reset values; the mode bit resets to the inverse of MODE_DEFAULT
    // ****************************************************************
    localparam logic [15:0] PPF_DEFAULT = 16'h0064;
    localparam logic POL_DEFAULT = 1'b0;
    localparam logic MODE_DEFAULT = 1'b0;

    // Frame-rate codes
    typedef enum logic [2:0] {
        RATE_30,
        RATE_30_DF,
        RATE_2997,
        RATE_2997_DF,
        RATE_25,
        RATE_24
    } frame_rate_t;

    localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

endpackage

// ---- motion_source.sv ----
// Partner model: film transport driving the two motion pins.
// Assumes the bench calls run() from its main process, clocked by the system clock.
`timescale 1ns/100ps

module motion_source (
    input wire logic clock,
    output logic motion_a,
    output logic motion_b
);
    initial begin
        motion_a = 1'b0;
        motion_b = 1'b0;
    end

    // Four steps per pulse, four clocks each, so each level lasts over three clocks
    task automatic run(input int n, input bit quad, input bit a_lead, input bit b_lvl);
        bit a_v;
        bit b_v;
        @(posedge clock);
        motion_b <= quad ? 1'b0 : b_lvl;
        repeat (4) @(posedge clock);
        for (int p = 0; p < n; p++) begin
            for (int k = 0; k < 4; k++) begin
                a_v = (k < 2);
                b_v = (k == 1 || k == 2);
                // Second wave trails the first by one step of four
                motion_a <= (quad && !a_lead) ? b_v : a_v;
                motion_b <= !quad ? b_lvl : (a_lead ? b_v : a_v);
                repeat (4) @(posedge clock);
            end
        end
    endtask
endmodule // motion_source

// ---- motion_decoder_bench.sv ----
// Testbench: register access over Wishbone classic and motion bursts.
// Assumes motion_decoder and motion_source compile before this file.
`timescale 1ns/100ps

module motion_decoder_bench;
    logic clock = 1'b0;
    logic reset = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [3:0] wb_adr_i = 4'h0;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0000_0000;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic motion_a;
    logic motion_b;
    logic clock_ref_r;
    logic direction_r;
    logic [23:0] position_r;
    logic [31:0] rd;
    logic [23:0] exp_pos;
    int miscompares = 0;
    int checks_done = 0;
    int ref_count = 0;
    int sent = 0;
    int phase = 0;
    bit mode_v;
    bit pol_v;
    bit loaded_v = 0;

    always #10 clock = ~clock;

    // Counted pulses seen on the clock reference output
    always @(posedge clock) begin
        if (clock_ref_r === 1'b1) begin
            ref_count <= ref_count + 1;
        end
    end

    motion_decoder motion_decoder_inst (.clock(clock), .reset(reset), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .motion_a(motion_a),
        .motion_b(motion_b), .clock_ref_r(clock_ref_r), .direction_r(direction_r),
        .position_r(position_r));

    motion_source motion_source_inst (.clock(clock), .motion_a(motion_a), .motion_b(motion_b));

    task automatic print_verdict();
        $display("checks %0d, mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // One classic cycle; read data taken at the ack edge only
    task automatic wb_xfer(input bit we, input logic [3:0] adr, input logic [31:0] dat);
        int n;
        @(posedge clock);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_sel_i <= 4'hF;
        wb_dat_i <= dat;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
        if (n >= 20) begin
            miscompares++;
            $display("[ERR] %0t bus access timed out", $time);
            print_verdict();
        end
    endtask

    // Burst from the transport, with the expected count stepped alongside
    task automatic move(input int n, input bit quad, input bit a_lead, input bit b_lvl);
        bit fwd;
        fwd = quad ? (a_lead ^ pol_v) : (~b_lvl ^ pol_v);
        motion_source_inst.run(n, quad, a_lead, b_lvl);
        sent += n;
        for (int i = 0; i < n && loaded_v; i++) begin
            if (fwd) begin
                phase = (phase == 3) ? 0 : phase + 1;
                exp_pos = (phase == 0) ? exp_pos + 24'h000001 : exp_pos;
            end else begin
                exp_pos = (phase == 0) ? exp_pos - 24'h000001 : exp_pos;
                phase = (phase == 0) ? 3 : phase - 1;
            end
        end
        repeat (8) @(posedge clock);
        check({31'h0, direction_r}, {31'h0, fwd});
        check({8'h00, position_r}, {8'h00, exp_pos});
    endtask

    initial begin
        repeat (10) @(posedge clock);
        reset <= 1'b0;
        wb_xfer(0, motion_decoder_pkg::ADDR_CTRL, 0);
        check(rd, 32'h0001_0001);
        wb_xfer(0, motion_decoder_pkg::ADDR_PPF, 0);
        check(rd, 32'h0000_0064);
        wb_xfer(0, 4'h2, 0);
        check(rd, motion_decoder_pkg::WORD_ZERO);
        for (int r = 0; r < 6; r++) begin
            wb_xfer(1, motion_decoder_pkg::ADDR_CTRL, (r << 4) | 1);
            wb_xfer(0, motion_decoder_pkg::ADDR_CTRL, 0);
            check(rd, 32'h0001_0001 | (r << 4));
        end
        mode_v = 1;
        pol_v = 0;
        exp_pos = 24'h000000;
        move(3, 1, 1, 0);
        wb_xfer(1, motion_decoder_pkg::ADDR_PPF, 32'h0000_0004);
        wb_xfer(1, motion_decoder_pkg::ADDR_START, 32'h0000_0010);
        wb_xfer(1, motion_decoder_pkg::ADDR_CTRL, 32'h0000_0101);
        loaded_v = 1;
        exp_pos = 24'h000010;
        repeat (3) @(posedge clock);
        check({8'h00, position_r}, 32'h0000_0010);
        move(4, 1, 1, 0);
        move(5, 1, 0, 0);
        wb_xfer(1, motion_decoder_pkg::ADDR_CTRL, 32'h0000_0003);
        pol_v = 1;
        move(2, 1, 1, 0);
        move(1, 1, 0, 0);
        wb_xfer(1, motion_decoder_pkg::ADDR_CTRL, 32'h0000_0000);
        pol_v = 0;
        move(3, 0, 0, 0);
        move(2, 0, 0, 1);
        wb_xfer(1, motion_decoder_pkg::ADDR_CTRL, 32'h0000_0002);
        pol_v = 1;
        move(2, 0, 0, 1);
        move(1, 0, 0, 0);
        check(ref_count, sent);
        wb_xfer(0, motion_decoder_pkg::ADDR_POS, 0);
        check(rd, {8'h00, exp_pos});
        // Mid-run reset must clear position and the loaded flag again
        reset <= 1'b1;
        repeat (3) @(posedge clock);
        reset <= 1'b0;
        wb_xfer(0, motion_decoder_pkg::ADDR_POS, 0);
        check(rd, motion_decoder_pkg::WORD_ZERO);
        wb_xfer(0, motion_decoder_pkg::ADDR_CTRL, 0);
        check(rd, 32'h0001_0001);
        print_verdict();
    end
endmodule // motion_decoder_bench
